// [design/iepg_consts.svh]
// Overview of operation
// - Enable bit 7 is the master gate; clear blocks every source.
// - A request passes only when master and its own enable are one.
// - Each source enable bit: zero disables, one enables that source.
// - Serial1 enable at bit 6, serial0 at bit 4; read/write, reset zero.
// - Timer1 enable at bit 3, timer0 at bit 1; read/write, reset zero.
// - External 1 enable at bit 2; read/write, reset zero, one enables.
// - Priority bit zero means low level, one means high; reset zero.
// - With master enable zero, no request is acknowledged.
// - Same level: lowest fixed interrupt number is served first.
`ifndef IEPG_CONSTS_SVH
`define IEPG_CONSTS_SVH
`define IEPG_ADDR_ENABLE 8'hA8
`define IEPG_ADDR_PRIORITY 8'hB8
`define IEPG_ENABLE_RESET 8'h00
`define IEPG_PRIORITY_RESET 8'h00
`define IEPG_BIT_MASTER 7
`define IEPG_BIT_SERIAL1 6
`define IEPG_BIT_RSVD 5
`define IEPG_BIT_SERIAL0 4
`define IEPG_BIT_TIMER1 3
`define IEPG_BIT_EXT1 2
`define IEPG_BIT_TIMER0 1
`define IEPG_BIT_EXT0 0
`define IEPG_ENABLE_WMASK 8'hDF
`define IEPG_PRIORITY_WMASK 8'h5F
`define IEPG_NUM_SRC 6
`endif

// [design/iepg_pkg.sv]
package iepg_pkg;
  // Source index order follows the fixed hardware interrupt number
  typedef enum logic [2:0] {
    IEPG_SRC_EXT0, IEPG_SRC_TIMER0, IEPG_SRC_EXT1,
    IEPG_SRC_TIMER1, IEPG_SRC_SERIAL0, IEPG_SRC_SERIAL1
  } iepg_src_t;
  typedef logic [7:0] iepg_byte_t;
endpackage : iepg_pkg

// [design/iepg_sel_if.sv]
`timescale 1ns/1ps
interface iepg_sel_if #(parameter int NSRC = 6);
  logic [NSRC-1:0] armed;
  logic [NSRC-1:0] high;
  logic valid;
  logic [2:0] index;
  logic level;
  modport gate (output armed, output high, input valid, input index, input level);
  modport arb (input armed, input high, output valid, output index, output level);
endinterface : iepg_sel_if

// [design/iepg_arbiter.sv]
`timescale 1ns/1ps
module iepg_arbiter #(
  parameter int NSRC = 6
) (
  iepg_sel_if.arb sel
);
  logic [NSRC-1:0] hi_req;
  logic [NSRC-1:0] lo_req;
  logic [NSRC-1:0] pick;
  logic [2:0] hi_idx;
  logic [2:0] lo_idx;

  assign hi_req = sel.armed & sel.high;
  assign lo_req = sel.armed & ~sel.high;
  // High level wins over low when any high request is armed
  assign pick = (|hi_req) ? hi_req : lo_req;

  // Lowest set index wins inside the chosen level
  always_comb begin
    hi_idx = 3'h0;
    lo_idx = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pick[i]) begin
        hi_idx = 3'(i);
      end
    end
    lo_idx = hi_idx;
  end

  assign sel.valid = |sel.armed;
  assign sel.index = lo_idx;
  assign sel.level = |hi_req;
endmodule : iepg_arbiter

// [design/iepg_gate.sv]
`timescale 1ns/1ps
`include "iepg_consts.svh"
module iepg_gate #(
  parameter int NSRC = `IEPG_NUM_SRC
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Request side, index is the fixed interrupt number order
  input wire logic [NSRC-1:0] irq_req_i,
  // Core side
  input wire logic irq_ack_i,
  output logic irq_valid_o,
  output logic [2:0] irq_index_o,
  output logic irq_level_o,
  output logic [NSRC-1:0] irq_gated_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  iepg_pkg::iepg_byte_t enable_r;
  iepg_pkg::iepg_byte_t enable_nxt;
  iepg_pkg::iepg_byte_t priority_r;
  iepg_pkg::iepg_byte_t priority_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic wr_enable;
  logic wr_priority;

  assign wr_enable = wr_i && (addr_i == `IEPG_ADDR_ENABLE);
  assign wr_priority = wr_i && (addr_i == `IEPG_ADDR_PRIORITY);
  // Reserved bit 5 is never stored, so it reads zero and cannot gate
  assign enable_nxt = wr_enable ? (wdata_i & `IEPG_ENABLE_WMASK) : enable_r;
  assign priority_nxt = wr_priority ? (wdata_i & `IEPG_PRIORITY_WMASK) : priority_r;

  // Unmapped addresses read zero
  assign rdata_nxt = !rd_i ? 8'h00 :
                     (addr_i == `IEPG_ADDR_ENABLE) ? enable_r :
                     (addr_i == `IEPG_ADDR_PRIORITY) ? priority_r : 8'h00;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_r <= `IEPG_ENABLE_RESET;
      priority_r <= `IEPG_PRIORITY_RESET;
      rdata_r <= 8'h00;
    end else begin
      enable_r <= enable_nxt;
      priority_r <= priority_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-source gating
  logic master_irq_enable;
  logic [NSRC-1:0] src_enable;
  logic [NSRC-1:0] src_priority;

  assign master_irq_enable = enable_r[`IEPG_BIT_MASTER];
  // Map register bits onto source numbers; bit 5 is skipped
  assign src_enable = {enable_r[`IEPG_BIT_SERIAL1], enable_r[`IEPG_BIT_SERIAL0],
                       enable_r[`IEPG_BIT_TIMER1], enable_r[`IEPG_BIT_EXT1],
                       enable_r[`IEPG_BIT_TIMER0], enable_r[`IEPG_BIT_EXT0]};
  assign src_priority = {priority_r[`IEPG_BIT_SERIAL1], priority_r[`IEPG_BIT_SERIAL0],
                         priority_r[`IEPG_BIT_TIMER1], priority_r[`IEPG_BIT_EXT1],
                         priority_r[`IEPG_BIT_TIMER0], priority_r[`IEPG_BIT_EXT0]};

  iepg_sel_if #(.NSRC(NSRC)) sel ();

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_src
      // Both master and own enable must be one
      assign sel.armed[g] = irq_req_i[g] & src_enable[g] & master_irq_enable;
      assign sel.high[g] = src_priority[g];
    end
  endgenerate

  iepg_arbiter #(.NSRC(NSRC)) u_arb (
    .sel(sel.arb)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Core-facing outputs, registered; a pending ack cannot resurrect a
  // request once master enable drops since valid is re-evaluated each cycle
  logic valid_r;
  logic [2:0] index_r;
  logic level_r;
  logic [NSRC-1:0] gated_r;

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      valid_r <= 1'b0;
      index_r <= 3'h0;
      level_r <= 1'b0;
      gated_r <= '0;
    end else begin
      valid_r <= sel.valid & master_irq_enable;
      index_r <= sel.index;
      level_r <= sel.level;
      gated_r <= sel.armed;
    end
  end

  assign rdata_o = rdata_r;
  assign irq_valid_o = valid_r;
  assign irq_index_o = index_r;
  assign irq_level_o = level_r;
  assign irq_gated_o = gated_r;
endmodule : iepg_gate

// [verification/iepg_src.sv]
`timescale 1ns/1ps
module iepg_src (
  input wire logic clk_i,
  input wire logic [5:0] set_i,
  output logic [5:0] req_o
);
  always_ff @(posedge clk_i) req_o <= set_i;
endmodule : iepg_src

// [verification/iepg_gate_assertions.sv]
`timescale 1ns/1ps
module iepg_chk #(parameter int NSRC = 6) (
  input wire logic mclk_i, input wire logic reset_n_i,
  input wire logic [7:0] addr_i, input wire logic [7:0] wdata_i,
  input wire logic wr_i, input wire logic rd_i, input wire logic [7:0] rdata_o,
  input wire logic [NSRC-1:0] irq_req_i, input wire logic [NSRC-1:0] irq_gated_o,
  input wire logic irq_valid_o, input wire logic [2:0] irq_index_o, input wire logic irq_level_o
);
  logic [7:0] en;
  logic [7:0] pr;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  // Shadows of the enable and priority registers
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      en <= 8'h00;
      pr <= 8'h00;
    end else if (wr_i && addr_i == 8'hA8) begin
      en <= wdata_i & 8'hDF;
    end else if (wr_i && addr_i == 8'hB8) begin
      pr <= wdata_i & 8'h5F;
    end
  end
  a_gate_exact: assert property (irq_gated_o == ($past(irq_req_i) &
    $past({en[6], en[4:0]} & {6{en[7]}}))) else $error("g");
  a_read_back: assert property (rd_i && addr_i == 8'hA8 |=>
    rdata_o == en) else $error("r");
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("z");
  a_master_off: assert property (!en[7] |=> !irq_valid_o) else $error("m");
  a_valid_any: assert property (irq_valid_o == |irq_gated_o) else $error("v");
  a_index_hit: assert property (irq_valid_o |-> irq_gated_o[irq_index_o]) else $error("i");
  a_low_first: assert property (irq_valid_o && !irq_level_o |->
    ((irq_gated_o & ((6'h01 << irq_index_o) - 6'h01)) == 6'h00)) else $error("o");
  a_level_valid: assert property (irq_level_o |-> irq_valid_o) else $error("l");
  a_level_match: assert property (irq_level_o ==
    |(irq_gated_o & $past({pr[6], pr[4:0]}))) else $error("level mismatch");
  a_high_first: assert property (irq_valid_o && irq_level_o |->
    ((irq_gated_o & $past({pr[6], pr[4:0]}) & ((6'h01 << irq_index_o) - 6'h01)) == 6'h00))
    else $error("high order");
endmodule : iepg_chk
bind iepg_gate iepg_chk #(.NSRC(NSRC)) u_iepg_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_req_i(irq_req_i),
  .irq_gated_o(irq_gated_o), .irq_valid_o(irq_valid_o), .irq_index_o(irq_index_o),
  .irq_level_o(irq_level_o)
);

// [verification/tb_iepg_gate.sv]
`timescale 1ns/1ps
module tb_iepg_gate;
  logic clk = 0, rn = 0, wr = 0, rd = 0, pd = 0, vld, lvl;
  logic [7:0] a = 0, d = 0, ro, e, p, q[$];
  logic [5:0] s = 0, rq, g, x, h, k;
  logic [2:0] ix;
  int errors = 0, samples_checked = 0;
  iepg_gate u_iepg_gate (.mclk_i(clk), .reset_n_i(rn), .addr_i(a), .wdata_i(d), .wr_i(wr),
    .rd_i(rd), .rdata_o(ro), .irq_req_i(rq), .irq_ack_i(vld), .irq_valid_o(vld),
    .irq_index_o(ix), .irq_level_o(lvl), .irq_gated_o(g));
  iepg_src u_iepg_src (.clk_i(clk), .set_i(s), .req_o(rq));
  task chk(input logic [7:0] v, w);
    samples_checked++;
    errors += int'(v !== w);
    if (v !== w) $display("ERROR %0t mismatch got %h expected %h", $time, v, w);
  endtask : chk
  // A read carries its expected value on the idle data lines
  task bus(input logic w, r, logic [7:0] ad, dv);
    wr <= w;
    rd <= r;
    a <= ad;
    d <= dv;
    if (r) q.push_back(dv);
    @(posedge clk);
  endtask : bus
  task results(input int t);
    errors += t;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  always @(posedge clk) pd <= rd;
  always @(negedge clk) if (pd) chk(ro, q.pop_front());
  initial forever #4 clk = ~clk;
  initial #20000 results(1);
  initial begin
    void'($urandom(55));
    repeat (8) @(posedge clk);
    rn <= 1'h1;
    bus(0, 1, 8'hA8, 8'h00);
    bus(0, 1, 8'h11, 8'h00);
    repeat (60) begin
      {e, p} = 16'($urandom);
      s <= 6'($urandom);
      bus(1, 0, 8'hA8, e);
      bus(1, 0, 8'hB8, p);
      bus(0, 1, 8'hA8, e & 8'hDF);
      bus(0, 1, 8'hB8, p & 8'h5F);
      bus(0, 0, 8'h00, 8'h00);
      @(negedge clk);
      x = s & {e[6], e[4:0]} & {6{e[7]}};
      h = x & {p[6], p[4:0]};
      for (int i = 5; i >= 0; i--) if (h != 0 ? h[i] : x[i]) k = 6'(i);
      chk({2'h0, g}, {2'h0, x});
      if (x != 0) chk({3'h0, vld, lvl, ix}, {4'h1, h != 0, k[2:0]});
      else chk({7'h00, vld}, 8'h00);
      // Next stimulus starts right after a rising edge, as the bus master must
      @(posedge clk);
    end
    results(0);
  end
endmodule : tb_iepg_gate
